// ---- rtl/cd_locator_pkg.sv ----
package cd_locator_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] ENTRY0_OFF     = 8'h00;
	localparam logic [7:0] ENTRY1_OFF     = 8'h04;
	localparam logic [7:0] ENTRY2_OFF     = 8'h08;
	localparam logic [7:0] ENTRY3_OFF     = 8'h0C;
	localparam logic [7:0] CAPS_OFF       = 8'h10;
	localparam logic [7:0] REQUEST_OFF    = 8'h14;
	localparam logic [7:0] RESULT_OFF     = 8'h18;
	localparam logic [7:0] ADDR_LO_OFF    = 8'h1C;
	localparam logic [7:0] ADDR_HI_OFF    = 8'h20;
	localparam logic [7:0] L1_LO_OFF      = 8'h24;
	localparam logic [7:0] L1_HI_OFF      = 8'h28;
	localparam logic [7:0] LEAF_LO_OFF    = 8'h2C;
	localparam logic [7:0] LEAF_HI_OFF    = 8'h30;
	localparam logic [7:0] EVENT_OFF      = 8'h34;
	// Entry field positions (72-bit entry image)
	localparam int FMT_LSB       = 4;
	localparam int PTR_LSB       = 6;
	localparam int PTR_MSB       = 55;
	localparam int COUNT_LSB     = 59;
	localparam int DSS_LSB       = 64;
	localparam int IR_LSB        = 66;
	localparam int OR_LSB        = 68;
	localparam int SH_LSB        = 70;
	localparam int CFG_LSB       = 1;
	// Encodings
	localparam logic [1:0] FMT_LINEAR  = 2'h0;
	localparam logic [1:0] FMT_LEAF4K  = 2'h1;
	localparam logic [1:0] FMT_LEAF64K = 2'h2;
	localparam logic [1:0] DSS_ABORT   = 2'h0;
	localparam logic [1:0] DSS_BYPASS  = 2'h1;
	localparam logic [1:0] DSS_USE0    = 2'h2;
	localparam logic [1:0] SH_NON      = 2'h0;
	localparam logic [1:0] SH_OUTER    = 2'h2;
	localparam logic [1:0] ATTR_NC     = 2'h0;
	localparam int LEAF4K_BITS   = 6;
	localparam int LEAF64K_BITS  = 10;
	localparam int CD_SHIFT      = 6;
	localparam int L1_SHIFT      = 3;
	localparam logic [4:0] CAPS_SSID_RESET = 5'h14;
	localparam logic [31:0] APB_ERR_DATA = 32'h0000_0000;
	typedef enum logic [2:0] {
		RES_IDLE, RES_DIRECT, RES_BYPASS, RES_BAD_SUB, RES_DISABLED,
		RES_BAD_ENTRY, RES_CA
	} result_t;
	typedef enum {ST_IDLE, ST_L1, ST_DONE} phase_t;
endpackage : cd_locator_pkg

// ---- rtl/stage1_cd_locator.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Zero count or zero id width: one descriptor at base, format ignored.
// - Linear format indexes substream low bits; table aligned to its size.
// - 4KB leaves of 64; leaf index id[5:0], level one upper bits.
// - 64KB leaves of 1024; index id[9:0]; leaf pointer low 16 zero.
// - Level one tables aligned to max(size, 64 bytes); code aligns only to size (16 or 32 bytes) for count 7-8 (4KB) and 11-12 (64KB); leaf low 12 zero.
// - Reserved format and default behaviour 0b11 act as 0b00.
// - Reserved pointer bits are treated as zero.
// - Stage 1 disabled: substream transactions abort, bad substream event.
// - Zero id width: count ignored, substream transactions abort with event.
// - Nonzero format without two-level support makes entry illegal.
// - Base pointer is entry bits 55:6, other address bits zero.
// - Stage 2 enabled marks base and level one pointers as intermediate.
// - Count field bits 63:59; descriptors number two to that power.
// - Count zero: substream_valid transactions abort with bad substream.
// - Index below two to count selects its descriptor, else abort.
// - Count above id width is illegal.
// - Default behaviour bits 65:64; 0b00 aborts with stream disabled.
// - 0b01 skips stage 1, fetches no descriptor, stage 2 if enabled.
// - 0b10 uses descriptor 0; explicit substream 0 aborts, disabled event.
// - Translation requests ended by 0b00 or 0b10 complete abort, no event.
// - Inner attribute bits 67:66 drive descriptor fetch inner cacheability.
// - Stage 2 enabled: fetch attributes flagged for combination.
// - Illegal entry behaves as invalid: abort with bad entry event; translation requests here complete abort, no event.
// - Outer attribute bits 69:68, same encodings as inner.
// - Shareability bits 71:70, 0b01 as 0b00; all non-cacheable is outer.
module stage1_cd_locator
	import cd_locator_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Level one pointer word read back from descriptor memory
	input  wire logic [63:0] l1_entry_data,
	// Fetch outcome
	output logic             lookup_done,
	output logic             abort_out
);
	import cd_locator_pkg::*;

	logic [71:0] entry_reg;
	logic [4:0]  ssid_width_reg;
	logic        two_level_reg;
	logic [19:0] sub_index_reg;
	logic        sub_valid_reg;
	logic        is_ats_reg;
	result_t     result_reg;
	logic [55:0] cd_addr_reg;
	logic [55:0] l1_addr_reg;
	logic [55:0] leaf_reg;
	logic        is_ipa_reg;
	logic        combine_reg;
	logic [5:0]  attr_reg;
	logic [2:0]  event_reg;
	logic        busy_reg;
	logic        lookup_done_reg;
	logic        abort_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	phase_t      phase_reg;

	wire logic access = psel && penable && !pready_reg;
	wire logic wr     = access && pwrite;
	wire logic rd     = access && !pwrite;
	wire logic start  = wr && paddr == REQUEST_OFF;

	// Decode shared by the request decision
	function automatic logic [1:0] norm2(input logic [1:0] v);
		return (v == 2'h3) ? 2'h0 : v;
	endfunction : norm2

	function automatic logic [55:0] mask_low(input logic [55:0] a,
		input logic [4:0] n);
		logic [55:0] m;
		m = ~((56'h1 << n) - 56'h1);
		return a & m;
	endfunction : mask_low

	wire logic [2:0] cfg   = entry_reg[CFG_LSB +: 3];
	wire logic [1:0] fmt   = norm2(entry_reg[FMT_LSB +: 2]);
	wire logic [1:0] dss   = norm2(entry_reg[DSS_LSB +: 2]);
	wire logic [4:0] cnt   = entry_reg[COUNT_LSB +: 5];
	wire logic [55:0] base = {entry_reg[PTR_MSB:PTR_LSB], 6'h00};
	wire logic valid_e     = entry_reg[0];
	wire logic s1_on       = cfg[2] && cfg[0];
	wire logic s2_on       = cfg[2] && cfg[1];
	wire logic subs_on     = ssid_width_reg != 5'h00 && cnt != 5'h00;

	logic    illegal;
	result_t decide;
	logic [19:0] eff_index;
	always_comb begin
		illegal = !valid_e || !cfg[2];
		if (s1_on && ssid_width_reg != 5'h00 && cnt > ssid_width_reg)
			illegal = 1'b1;
		if (s1_on && subs_on && !two_level_reg && fmt != FMT_LINEAR)
			illegal = 1'b1;
		eff_index = sub_index_reg;
		decide    = RES_DIRECT;
		if (illegal) begin
			decide = is_ats_reg ? RES_CA : RES_BAD_ENTRY;
		end else if (!s1_on) begin
			decide = sub_valid_reg ? RES_BAD_SUB : RES_BYPASS;
		end else if (ssid_width_reg == 5'h00) begin
			decide = sub_valid_reg ? RES_BAD_SUB : RES_DIRECT;
		end else if (cnt == 5'h00) begin
			decide = sub_valid_reg ? RES_BAD_SUB : RES_DIRECT;
		end else if (sub_valid_reg) begin
			if ((32'(sub_index_reg) >> cnt) != 32'h0000_0000)
				decide = RES_BAD_SUB;
			else if (dss == DSS_USE0 && sub_index_reg == 20'h0_0000)
				decide = is_ats_reg ? RES_CA : RES_DISABLED;
		end else begin
			unique case (dss)
			DSS_BYPASS: decide = RES_BYPASS;
			DSS_USE0: eff_index = 20'h0_0000;
			default: decide = is_ats_reg ? RES_CA : RES_DISABLED;
			endcase
		end
	end

	wire logic use_leafs = subs_on && fmt != FMT_LINEAR;

	// Request decision and address forming
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			result_reg  <= RES_IDLE;
			cd_addr_reg <= 56'h00_0000_0000_0000;
			l1_addr_reg <= 56'h00_0000_0000_0000;
			leaf_reg    <= 56'h00_0000_0000_0000;
			is_ipa_reg  <= 1'b0;
			combine_reg <= 1'b0;
			attr_reg    <= 6'h00;
			phase_reg   <= ST_IDLE;
			busy_reg    <= 1'b0;
			lookup_done_reg <= 1'b0;
			abort_reg   <= 1'b0;
		end else begin
			lookup_done_reg <= 1'b0;
			unique case (phase_reg)
			ST_IDLE: if (start) begin
				busy_reg  <= 1'b1;
				phase_reg <= ST_L1;
			end
			ST_L1: begin
				result_reg  <= decide;
				is_ipa_reg  <= s2_on;
				combine_reg <= s2_on;
				attr_reg[1:0] <= entry_reg[IR_LSB +: 2];
				attr_reg[3:2] <= entry_reg[OR_LSB +: 2];
				if (entry_reg[IR_LSB +: 2] == ATTR_NC &&
					entry_reg[OR_LSB +: 2] == ATTR_NC)
					attr_reg[5:4] <= SH_OUTER;
				else if (entry_reg[SH_LSB +: 2] == 2'h1)
					attr_reg[5:4] <= SH_NON;
				else
					attr_reg[5:4] <= entry_reg[SH_LSB +: 2];
				if (decide != RES_DIRECT) begin
					cd_addr_reg <= 56'h00_0000_0000_0000;
				end else if (!subs_on) begin
					cd_addr_reg <= base;
				end else if (fmt == FMT_LINEAR) begin
					cd_addr_reg <= mask_low(base, 5'(cnt + 5'd6))
						+ (56'(eff_index) << CD_SHIFT);
				end else if (fmt == FMT_LEAF4K) begin
					l1_addr_reg <= mask_low(base,
						(cnt > 5'd6) ? 5'(cnt - 5'd3) : 5'd6)
						+ ((56'(eff_index) >> LEAF4K_BITS)
						<< L1_SHIFT);
				end else begin
					l1_addr_reg <= mask_low(base,
						(cnt > 5'd10) ? 5'(cnt - 5'd7) : 5'd6)
						+ ((56'(eff_index) >> LEAF64K_BITS)
						<< L1_SHIFT);
				end
				phase_reg <= (decide == RES_DIRECT && use_leafs)
					? ST_DONE : ST_IDLE;
				if (!(decide == RES_DIRECT && use_leafs)) begin
					busy_reg        <= 1'b0;
					lookup_done_reg <= 1'b1;
					abort_reg       <= decide != RES_DIRECT &&
						decide != RES_BYPASS;
				end
			end
			ST_DONE: begin
				// Pointer word supplied by memory completes the second level
				if (fmt == FMT_LEAF4K) begin
					leaf_reg <= {l1_entry_data[55:12], 12'h000};
					cd_addr_reg <= {l1_entry_data[55:12], 12'h000}
						+ (56'(eff_index[5:0]) << CD_SHIFT);
				end else begin
					leaf_reg <= {l1_entry_data[55:16], 16'h0000};
					cd_addr_reg <= {l1_entry_data[55:16], 16'h0000}
						+ (56'(eff_index[9:0]) << CD_SHIFT);
				end
				busy_reg        <= 1'b0;
				lookup_done_reg <= 1'b1;
				abort_reg       <= 1'b0;
				phase_reg       <= ST_IDLE;
			end
			default: phase_reg <= ST_IDLE;
			endcase
		end
	end

	// Sticky event flags: set wins over software clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			event_reg <= 3'h0;
		end else begin
			logic [2:0] set;
			set = 3'h0;
			if (phase_reg == ST_L1) begin
				set[0] = decide == RES_BAD_SUB;
				set[1] = decide == RES_DISABLED;
				set[2] = decide == RES_BAD_ENTRY;
			end
			if (wr && paddr == EVENT_OFF)
				event_reg <= (event_reg & ~pwdata[2:0]) | set;
			else
				event_reg <= event_reg | set;
		end
	end

	// Configuration writes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			entry_reg      <= 72'h0;
			ssid_width_reg <= CAPS_SSID_RESET;
			two_level_reg  <= 1'b1;
			sub_index_reg  <= 20'h0_0000;
			sub_valid_reg  <= 1'b0;
			is_ats_reg     <= 1'b0;
		end else if (wr && !busy_reg) begin
			unique case (paddr)
			ENTRY0_OFF: entry_reg[31:0]  <= pwdata;
			ENTRY1_OFF: entry_reg[63:32] <= pwdata;
			ENTRY2_OFF: entry_reg[71:64] <= pwdata[7:0];
			CAPS_OFF: begin
				ssid_width_reg <= pwdata[4:0];
				two_level_reg  <= pwdata[8];
			end
			REQUEST_OFF: begin
				sub_index_reg <= pwdata[19:0];
				sub_valid_reg <= pwdata[20];
				is_ats_reg    <= pwdata[21];
			end
			default: ;
			endcase
		end
	end

	function automatic logic known(input logic [7:0] a);
		return a <= EVENT_OFF && a[1:0] == 2'h0 && a != ENTRY3_OFF;
	endfunction : known

	// APB answer: one wait state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= access;
			pslverr_reg <= access && !known(paddr);
			prdata_reg  <= APB_ERR_DATA;
			if (rd) begin
				unique case (paddr)
				ENTRY0_OFF:  prdata_reg <= entry_reg[31:0];
				ENTRY1_OFF:  prdata_reg <= entry_reg[63:32];
				ENTRY2_OFF:  prdata_reg <= {24'h00_0000, entry_reg[71:64]};
				CAPS_OFF:    prdata_reg <= {23'h0, two_level_reg,
					3'h0, ssid_width_reg};
				REQUEST_OFF: prdata_reg <= {10'h000, is_ats_reg,
					sub_valid_reg, sub_index_reg};
				RESULT_OFF:  prdata_reg <= {16'h0000, 2'h0, attr_reg,
					combine_reg, is_ipa_reg, 1'b0, busy_reg, 1'b0,
					result_reg};
				ADDR_LO_OFF: prdata_reg <= cd_addr_reg[31:0];
				ADDR_HI_OFF: prdata_reg <= {8'h00, cd_addr_reg[55:32]};
				L1_LO_OFF:   prdata_reg <= l1_addr_reg[31:0];
				L1_HI_OFF:   prdata_reg <= {8'h00, l1_addr_reg[55:32]};
				LEAF_LO_OFF: prdata_reg <= leaf_reg[31:0];
				LEAF_HI_OFF: prdata_reg <= {8'h00, leaf_reg[55:32]};
				EVENT_OFF:   prdata_reg <= {29'h0, event_reg};
				default:     prdata_reg <= APB_ERR_DATA;
				endcase
			end
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign lookup_done = lookup_done_reg;
	assign abort_out   = abort_reg;

	a_apb_one_wait: assert property (@(posedge clk) disable iff (!reset_n)
		psel && penable && !pready |=> pready)
		else $error("APB answer late");
	a_bad_sub_flag: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && decide == RES_BAD_SUB |=> event_reg[0])
		else $error("Bad substream event missing");
	a_stage1_off_sub: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && !illegal && !s1_on && sub_valid_reg
		|=> result_reg == RES_BAD_SUB && abort_reg)
		else $error("Stage 1 off did not abort");
	a_count_zero_sub: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && !illegal && s1_on && cnt == 5'h00 &&
		sub_valid_reg |=> result_reg == RES_BAD_SUB)
		else $error("Count zero accepted substream");
	a_single_cd: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && decide == RES_DIRECT && !subs_on
		|=> cd_addr_reg == $past(base))
		else $error("Single descriptor address wrong");
	a_illegal_entry: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && illegal && !is_ats_reg
		|=> event_reg[2] && abort_reg)
		else $error("Illegal entry not reported");
	a_ats_no_event: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && is_ats_reg && decide == RES_CA
		|=> $stable(event_reg[1]))
		else $error("Translation request recorded event");
	a_dss_bypass: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && !illegal && s1_on && subs_on &&
		!sub_valid_reg && dss == DSS_BYPASS
		|=> result_reg == RES_BYPASS && !abort_reg)
		else $error("Bypass default not taken");
	a_nc_outer: assert property (@(posedge clk)
		disable iff (!reset_n)
		phase_reg == ST_L1 && entry_reg[IR_LSB +: 4] == 4'h0
		|=> attr_reg[5:4] == SH_OUTER)
		else $error("Shareability not outer");
	a_start_done: assert property (@(posedge clk) disable iff (!reset_n)
		start && !busy_reg |-> ##[2:3] lookup_done)
		else $error("Lookup did not finish");
	c_two_level: cover property (@(posedge clk) phase_reg == ST_DONE);
	c_bad_sub: cover property (@(posedge clk) event_reg[0]);
	c_bypass: cover property (@(posedge clk) result_reg == RES_BYPASS);
endmodule : stage1_cd_locator

// ---- sim/desc_mem_model.sv ----
`timescale 1ns/1ps
module desc_mem_model
	import cd_locator_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Observed request path
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic        pready,
	input  wire logic        lookup_done,
	// Pointer word held in every level one slot
	input  wire logic [63:0] leaf_word,
	output logic      [63:0] l1_entry_data
);
	logic busy_reg;

	// Word is valid only while a lookup is in flight
	always_ff @(posedge clk) begin
		if (!reset_n || lookup_done) begin
			busy_reg <= 1'b0;
		end else if (psel && penable && pwrite && !pready
			&& paddr == REQUEST_OFF) begin
			busy_reg <= 1'b1;
		end
	end

	// Outside a lookup the bus shows the inverse, never a stale match
	assign l1_entry_data = busy_reg ? leaf_word : ~leaf_word;
endmodule : desc_mem_model

// ---- sim/stage1_cd_locator_tb.sv ----
`timescale 1ns/1ps
module stage1_cd_locator_tb;
	import cd_locator_pkg::*;
	localparam logic [31:0] SUBSTREAM_VALID = 32'h0010_0000;
	localparam logic [31:0] ATS = 32'h0020_0000;
	logic        clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [63:0] l1_entry_data;
	logic        lookup_done;
	logic        abort_out;
	logic [31:0] q;
	logic        e;
	logic        done_seen;
	int          err_total;
	int          n_checks;

	stage1_cd_locator i_stage1_cd_locator (.clk(clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .l1_entry_data(l1_entry_data),
		.lookup_done(lookup_done), .abort_out(abort_out));
	desc_mem_model i_desc_mem_model (.clk(clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pready(pready), .lookup_done(lookup_done),
		.leaf_word(64'h0000_0000_3000_0001),
		.l1_entry_data(l1_entry_data));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (lookup_done === 1'b1) begin
			done_seen <= 1'b1;
		end
	end

	task stop_test;
		$display("Checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			stop_test();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check($sformatf("reg %h", a), q, exp);
	endtask : rd

	task ent(input logic [31:0] e0, input logic [31:0] e1,
		input logic [31:0] e2);
		apb(1'b1, ENTRY0_OFF, e0);
		apb(1'b1, ENTRY1_OFF, e1);
		apb(1'b1, ENTRY2_OFF, e2);
	endtask : ent

	task look(input logic [31:0] req, input logic [2:0] code);
		int n;
		logic [2:0] ev;
		done_seen <= 1'b0;
		apb(1'b1, REQUEST_OFF, req);
		n = 0;
		while (done_seen !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		check("lookup_done", {31'h0, done_seen}, 32'h1);
		check("abort_out", {31'h0, abort_out}, {31'h0,
			code inside {RES_BAD_SUB, RES_DISABLED, RES_BAD_ENTRY,
			RES_CA}});
		case (code)
			RES_BAD_SUB:   ev = 3'h1;
			RES_DISABLED:  ev = 3'h2;
			RES_BAD_ENTRY: ev = 3'h4;
			default:       ev = 3'h0;
		endcase
		apb(1'b0, RESULT_OFF, 32'h0000_0000);
		check("result", {29'h0, q[2:0]}, {29'h0, code});
		check("busy", {31'h0, q[4]}, 32'h0000_0000);
		apb(1'b0, EVENT_OFF, 32'h0000_0000);
		check("event", q, {29'h0, ev});
		apb(1'b1, EVENT_OFF, 32'h0000_0007);
	endtask : look

	initial begin
		#100000;
		err_total++;
		stop_test();
	end

	initial begin
		err_total = 0;
		n_checks  = 0;
		done_seen = 1'b0;
		reset_n   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0000_0000;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(CAPS_OFF, 32'h0000_0114);
		apb(1'b0, 8'h3C, 32'h0000_0000);
		check("unmapped", {31'h0, e}, 32'h1);
		apb(1'b1, ENTRY3_OFF, 32'h0000_0000);
		check("reserved", {31'h0, e}, 32'h1);
		ent(32'h1000_000B, 32'h2000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd5, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_0140);
		rd(ADDR_HI_OFF, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd15, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_03C0);
		look(SUBSTREAM_VALID | 32'd16, RES_BAD_SUB);
		look(32'h0, RES_DISABLED);
		look(ATS, RES_CA);
		apb(1'b1, ENTRY2_OFF, 32'h0000_0003);
		look(32'h0, RES_DISABLED);
		apb(1'b1, ENTRY2_OFF, 32'h0000_0001);
		look(32'h0, RES_BYPASS);
		apb(1'b1, ENTRY2_OFF, 32'h0000_0002);
		look(32'h0, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_0000);
		look(SUBSTREAM_VALID, RES_DISABLED);
		look(ATS | SUBSTREAM_VALID, RES_CA);
		ent(32'h1000_003B, 32'h2000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd5, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_0140);
		apb(1'b1, ENTRY0_OFF, 32'h1000_004B);
		look(SUBSTREAM_VALID | 32'd5, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_0140);
		ent(32'h1000_001B, 32'h0000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd1, RES_BAD_SUB);
		look(32'h0, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_0000);
		ent(32'h1000_000B, 32'hA000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'h000F_FFFF, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h13FF_FFC0);
		apb(1'b1, ENTRY1_OFF, 32'hA800_0000);
		look(SUBSTREAM_VALID | 32'd1, RES_BAD_ENTRY);
		ent(32'h1000_0009, 32'h2000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd1, RES_BAD_SUB);
		apb(1'b1, ENTRY0_OFF, 32'h1000_000D);
		look(SUBSTREAM_VALID | 32'd1, RES_BAD_SUB);
		apb(1'b1, ENTRY0_OFF, 32'h1000_000A);
		look(32'h0, RES_BAD_ENTRY);
		ent(32'h1000_001B, 32'h4000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'h4C, RES_DIRECT);
		rd(L1_LO_OFF, 32'h1000_0008);
		rd(LEAF_LO_OFF, 32'h3000_0000);
		rd(ADDR_LO_OFF, 32'h3000_0300);
		ent(32'h1000_002B, 32'h6000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'h805, RES_DIRECT);
		rd(L1_LO_OFF, 32'h1000_0010);
		rd(ADDR_LO_OFF, 32'h3000_0140);
		apb(1'b1, CAPS_OFF, 32'h0000_0014);
		ent(32'h1000_001B, 32'h4000_0000, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd1, RES_BAD_ENTRY);
		apb(1'b1, CAPS_OFF, 32'h0000_0000);
		look(SUBSTREAM_VALID | 32'd1, RES_BAD_SUB);
		look(32'h0, RES_DIRECT);
		rd(ADDR_LO_OFF, 32'h1000_0000);
		apb(1'b1, CAPS_OFF, 32'h0000_0114);
		ent(32'h1000_000F, 32'h2000_0000, 32'h0000_00E4);
		look(SUBSTREAM_VALID | 32'd5, RES_DIRECT);
		rd(RESULT_OFF, 32'h0000_39C1);
		check("attr", q & 32'h0000_3FC7, 32'h0000_39C1);
		ent(32'h1000_000B, 32'h2000_0000, 32'h0000_0040);
		look(SUBSTREAM_VALID | 32'd5, RES_DIRECT);
		apb(1'b0, RESULT_OFF, 32'h0000_0000);
		check("attr", q & 32'h0000_3FC7, 32'h0000_2001);
		apb(1'b1, ENTRY2_OFF, 32'h0000_0058);
		look(SUBSTREAM_VALID | 32'd5, RES_DIRECT);
		apb(1'b0, RESULT_OFF, 32'h0000_0000);
		check("attr", q & 32'h0000_3FC7, 32'h0000_0601);
		stop_test();
	end
endmodule : stage1_cd_locator_tb
